// [rtl/rssr_params.svh]
// Purpose: Offsets, field positions and reset values of the receiver and sensor status bank
// Assumes: Byte addresses are four times the printed register index
// Notes:   Definitions only
`ifndef RSSR_PARAMS_SVH
`define RSSR_PARAMS_SVH

`define RSSR_IDX_GAIN_STATE   8'h2D
`define RSSR_IDX_CAP_CTRL     8'h2E
`define RSSR_IDX_CAP_RESULT   8'h2F
`define RSSR_IDX_AUX_STATUS   8'h30
`define RSSR_IDX_IRQ_STATUS   8'h40
`define RSSR_IDX_IRQ_MASK     8'h41
`define RSSR_IDX_COMMAND      8'h42

`define RSSR_RESET_BYTE       8'h00
`define RSSR_CMD_SET_DEFAULT  8'hC1
`define RSSR_PSLVERR_UNMAPPED 1'b1

`define RSSR_AM_MSB           7
`define RSSR_AM_LSB           4
`define RSSR_PM_MSB           3
`define RSSR_PM_LSB           0
`define RSSR_CAL_MSB          7
`define RSSR_CAL_LSB          3
`define RSSR_CAL_END_BIT      2
`define RSSR_CAL_ERR_BIT      1
`define RSSR_GAIN_MSB         2
`define RSSR_GAIN_LSB         0
`define RSSR_CAL_AUTO_CODE    5'h00
// Sensor settings for an all-zero control byte: auto calibration, valid gain
`define RSSR_CFG_RESET        10'h201

`define RSSR_IRQ_CAL_END      0
`define RSSR_IRQ_CAL_ERR      1
`define RSSR_IRQ_FIELD_ON     2
`define RSSR_IRQ_OSC_OK       3
`define RSSR_IRQ_RX_START     4
`define RSSR_IRQ_WIDTH        5

`define RSSR_SYNC_WIDTH       13
`endif

// [rtl/rssr_pkg.sv]
// Purpose: Types of the receiver and sensor status bank
// Assumes: rssr_params.svh holds all numbers except the gain and bus state codes defined here
// Notes:   Groups of front end status travel as packed structs
package rssr_pkg;

    // Capacitive sensor gain codes, typical V/pF
    typedef enum logic [2:0] {
        RSSR_GAIN_2P8  = 3'b000,
        RSSR_GAIN_6P5  = 3'b001,
        RSSR_GAIN_1P1  = 3'b010,
        RSSR_GAIN_0P5  = 3'b100,
        RSSR_GAIN_0P35 = 3'b110
    } rssr_gain_t;

    // Live state from the analog and framing logic
    typedef struct packed {
        logic [3:0] am_gain_cut;
        logic [3:0] pm_gain_cut;
        logic       pm_selected;
        logic       field_detected;
        logic       tx_active;
        logic       osc_stable;
        logic       rx_enabled;
        logic       rx_busy;
        logic       peer_detect_active;
        logic       collision_avoid_active;
    } rssr_frontend_t;

    // Calibration engine report
    typedef struct packed {
        logic [4:0] cal_value;
        logic       cal_done;
        logic       cal_error;
    } rssr_cal_t;

    // Settings driven to the capacitive sensor
    typedef struct packed {
        logic       auto_cal;
        logic [4:0] manual_cal;
        logic [2:0] gain;
        logic       gain_valid;
    } rssr_sensor_cfg_t;

    typedef enum logic [1:0] {
        RSSR_APB_IDLE   = 2'b00,
        RSSR_APB_ACCESS = 2'b01
    } rssr_apb_state_t;

endpackage : rssr_pkg

// [rtl/rssr_regs.sv]
// Purpose: APB register bank for receiver gain, capacitive sensor and auxiliary status
// Assumes: Front end and calibration inputs come from other clock domains
// Notes:   Zero wait state APB slave; read-clear interrupt status
//
// How it works
// - Gain state bits 7..4 show the live AM second stage gain cut, MSB on top.
// - Gain state bits 3..0 show the live PM second stage gain cut, MSB on top.
// - All four registers read zero after reset; set-default clears them, but the three status registers reload live state on the next cycle.
// - A zero manual calibration code selects automatic calibration, else it is applied.
// - Calibration codes are binary weighted at 0.1 pF per step, 31 steps to 3.1 pF.
// - Gain codes 000,001,010,100,110 are valid sensor gains; other codes are unused.
// - Result register holds calibration value in 7..3, done in bit 2, error in bit 1.
// - Auxiliary bit 6 mirrors the external field detector.
// - Auxiliary bit 5 is set while the transmitter sends.
// - Auxiliary bit 4 is set only when the crystal oscillator runs stable.
// - Auxiliary bit 3 is set while the receive decoder is enabled.
// - Auxiliary bit 2 is set while the receive decoder takes in a message.
// - Auxiliary bit 1 is set while field detection runs in peer detection mode.
// - Auxiliary bit 0 is set while field detection runs in collision avoidance mode.
`timescale 1ns/1ns
`include "rssr_params.svh"

module rssr_regs (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     clk_en,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire rssr_pkg::rssr_frontend_t frontend,
    input  wire rssr_pkg::rssr_cal_t      cal_report,
    output rssr_pkg::rssr_sensor_cfg_t    sensor_cfg,
    output logic                          irq
);
    import rssr_pkg::*;

    //--------------------------------------------------------------
    // Address decode
    //--------------------------------------------------------------
    localparam int AW = 12;

    function automatic logic addr_is(input logic [AW-1:0] a, input logic [7:0] idx);
        addr_is = (a == {2'b00, idx, 2'b00});
    endfunction : addr_is

    function automatic logic addr_mapped(input logic [AW-1:0] a);
        addr_mapped = addr_is(a, `RSSR_IDX_GAIN_STATE) || addr_is(a, `RSSR_IDX_CAP_CTRL)
                   || addr_is(a, `RSSR_IDX_CAP_RESULT) || addr_is(a, `RSSR_IDX_AUX_STATUS)
                   || addr_is(a, `RSSR_IDX_IRQ_STATUS) || addr_is(a, `RSSR_IDX_IRQ_MASK)
                   || addr_is(a, `RSSR_IDX_COMMAND);
    endfunction : addr_mapped

    // Gain code legality
    function automatic logic gain_ok(input logic [2:0] g);
        case (g)
            RSSR_GAIN_2P8, RSSR_GAIN_6P5, RSSR_GAIN_1P1,
            RSSR_GAIN_0P5, RSSR_GAIN_0P35: gain_ok = 1'b1;
            default:                       gain_ok = 1'b0;
        endcase
    endfunction : gain_ok

    //--------------------------------------------------------------
    // Input synchronisers, three stages
    //--------------------------------------------------------------
    localparam int SW = `RSSR_SYNC_WIDTH;
    logic [SW-1:0] raw_in;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [SW-1:0] sync3;
    logic [SW-1:0] stable;

    assign raw_in = {frontend.pm_selected, frontend.field_detected, frontend.tx_active,
                     frontend.osc_stable, frontend.rx_enabled, frontend.rx_busy,
                     frontend.peer_detect_active, frontend.collision_avoid_active,
                     cal_report.cal_done, cal_report.cal_error,
                     frontend.am_gain_cut[0], frontend.pm_gain_cut[0], 1'b0};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else if (clk_en) begin
            sync1 <= raw_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Change taken once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_stable
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stable[gi] <= 1'b0;
                end else if (clk_en && (sync2[gi] == sync3[gi])) begin
                    stable[gi] <= sync3[gi];
                end
            end
        end
    endgenerate

    // Multi-bit codes: three stage pipes, accepted when two samples agree
    logic [15:0] code_s1;
    logic [15:0] code_s2;
    logic [15:0] code_s3;
    logic [15:0] code_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_s1 <= '0;
            code_s2 <= '0;
            code_s3 <= '0;
            code_ok <= '0;
        end else if (clk_en) begin
            code_s1 <= {frontend.am_gain_cut, frontend.pm_gain_cut, cal_report.cal_value,
                        3'b000};
            code_s2 <= code_s1;
            code_s3 <= code_s2;
            if (code_s2 == code_s3) begin
                code_ok <= code_s3;
            end
        end
    end

    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------
    logic [7:0]                cap_sensor_control;
    logic [7:0]                receive_gain_reduction_state;
    logic [7:0]                cap_sensor_result;
    logic [7:0]                auxiliary_status;
    logic [`RSSR_IRQ_WIDTH-1:0] irq_status;
    logic [`RSSR_IRQ_WIDTH-1:0] irq_mask;
    logic                      set_default;
    logic                      wr_access;
    logic                      rd_access;
    logic [`RSSR_IRQ_WIDTH-1:0] events;
    logic [`RSSR_IRQ_WIDTH-1:0] prev_level;
    logic [`RSSR_IRQ_WIDTH-1:0] cur_level;
    rssr_apb_state_t           apb_state;

    assign wr_access = psel && !penable && pwrite && clk_en;
    assign rd_access = psel && !penable && !pwrite && clk_en;
    assign set_default = wr_access && addr_is(paddr, `RSSR_IDX_COMMAND) && pstrb[0]
                      && (pwdata[7:0] == `RSSR_CMD_SET_DEFAULT);

    // Writable control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_sensor_control <= `RSSR_RESET_BYTE;
        end else if (set_default) begin
            cap_sensor_control <= `RSSR_RESET_BYTE;
        end else if (wr_access && addr_is(paddr, `RSSR_IDX_CAP_CTRL) && pstrb[0]) begin
            cap_sensor_control <= pwdata[7:0];
        end
    end

    // Live status snapshots; only the set-default command reaches them from the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_gain_reduction_state <= `RSSR_RESET_BYTE;
            cap_sensor_result            <= `RSSR_RESET_BYTE;
            auxiliary_status             <= `RSSR_RESET_BYTE;
        end else if (set_default) begin
            receive_gain_reduction_state <= `RSSR_RESET_BYTE;
            cap_sensor_result            <= `RSSR_RESET_BYTE;
            auxiliary_status             <= `RSSR_RESET_BYTE;
        end else if (clk_en) begin
            receive_gain_reduction_state[`RSSR_AM_MSB:`RSSR_AM_LSB] <= code_ok[15:12];
            receive_gain_reduction_state[`RSSR_PM_MSB:`RSSR_PM_LSB] <= code_ok[11:8];
            cap_sensor_result[`RSSR_CAL_MSB:`RSSR_CAL_LSB] <= code_ok[7:3];
            cap_sensor_result[`RSSR_CAL_END_BIT] <= stable[4];
            cap_sensor_result[`RSSR_CAL_ERR_BIT] <= stable[3];
            cap_sensor_result[0]                 <= 1'b0;
            auxiliary_status[7] <= stable[12];
            auxiliary_status[6] <= stable[11];
            auxiliary_status[5] <= stable[10];
            auxiliary_status[4] <= stable[9];
            auxiliary_status[3] <= stable[8];
            auxiliary_status[2] <= stable[7];
            auxiliary_status[1] <= stable[6];
            auxiliary_status[0] <= stable[5];
        end
    end

    // Sensor settings out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sensor_cfg <= `RSSR_CFG_RESET;
        end else if (clk_en) begin
            sensor_cfg.manual_cal <= cap_sensor_control[`RSSR_CAL_MSB:`RSSR_CAL_LSB];
            sensor_cfg.auto_cal   <= (cap_sensor_control[`RSSR_CAL_MSB:`RSSR_CAL_LSB]
                                      == `RSSR_CAL_AUTO_CODE);
            sensor_cfg.gain       <= cap_sensor_control[`RSSR_GAIN_MSB:`RSSR_GAIN_LSB];
            sensor_cfg.gain_valid <= gain_ok(
                cap_sensor_control[`RSSR_GAIN_MSB:`RSSR_GAIN_LSB]);
        end
    end

    //--------------------------------------------------------------
    // Interrupts: rising edges of status levels
    //--------------------------------------------------------------
    assign cur_level = {stable[7], stable[9], stable[11], stable[3], stable[4]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_level <= '0;
        end else if (clk_en) begin
            prev_level <= cur_level;
        end
    end

    assign events = cur_level & ~prev_level & {`RSSR_IRQ_WIDTH{clk_en}};

    // Set wins over the read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else if (rd_access && addr_is(paddr, `RSSR_IDX_IRQ_STATUS)) begin
            irq_status <= events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= '0;
        end else if (wr_access && addr_is(paddr, `RSSR_IDX_IRQ_MASK) && pstrb[0]) begin
            irq_mask <= pwdata[`RSSR_IRQ_WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(irq_status & irq_mask);
        end
    end

    //--------------------------------------------------------------
    // APB answer: data latched in setup, ready in access
    //--------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_state <= RSSR_APB_IDLE;
            prdata    <= '0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
        end else if (clk_en) begin
            case (apb_state)
                RSSR_APB_IDLE: begin
                    pready  <= 1'b0;
                    pslverr <= 1'b0;
                    if (psel && !penable) begin
                        apb_state <= RSSR_APB_ACCESS;
                        pready    <= 1'b1;
                        pslverr   <= addr_mapped(paddr) ? 1'b0 : `RSSR_PSLVERR_UNMAPPED;
                        prdata    <= '0;
                        if (!pwrite) begin
                            if (addr_is(paddr, `RSSR_IDX_GAIN_STATE)) begin
                                prdata[7:0] <= receive_gain_reduction_state;
                            end else if (addr_is(paddr, `RSSR_IDX_CAP_CTRL)) begin
                                prdata[7:0] <= cap_sensor_control;
                            end else if (addr_is(paddr, `RSSR_IDX_CAP_RESULT)) begin
                                prdata[7:0] <= cap_sensor_result;
                            end else if (addr_is(paddr, `RSSR_IDX_AUX_STATUS)) begin
                                prdata[7:0] <= auxiliary_status;
                            end else if (addr_is(paddr, `RSSR_IDX_IRQ_STATUS)) begin
                                prdata[`RSSR_IRQ_WIDTH-1:0] <= irq_status;
                            end else if (addr_is(paddr, `RSSR_IDX_IRQ_MASK)) begin
                                prdata[`RSSR_IRQ_WIDTH-1:0] <= irq_mask;
                            end
                        end
                    end
                end
                RSSR_APB_ACCESS: begin
                    apb_state <= RSSR_APB_IDLE;
                    pready    <= 1'b0;
                    pslverr   <= 1'b0;
                end
                default: begin
                    apb_state <= RSSR_APB_IDLE;
                    pready    <= 1'b0;
                end
            endcase
        end
    end

endmodule : rssr_regs

// [sim/rssr_regs_properties.sv]
// Purpose: Port level checks of the receiver and sensor status bank
// Assumes: One clock domain, clk_en high throughout the run
// Notes:   Bound to every rssr_regs instance
`timescale 1ns/1ns
module rssr_regs_checker (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     clk_en,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [11:0]              paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [3:0]               pstrb,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input wire rssr_pkg::rssr_frontend_t frontend,
    input wire rssr_pkg::rssr_cal_t      cal_report,
    input wire rssr_pkg::rssr_sensor_cfg_t sensor_cfg,
    input wire logic                     irq
);
    import rssr_pkg::*;
    logic [3:0] quiet_cnt;
    logic [7:0] last_cfg;
    // Cycles since live inputs last moved
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) quiet_cnt <= 4'h0;
        else if (!$stable(frontend) || !$stable(cal_report)) quiet_cnt <= 4'h0;
        else if (quiet_cnt != 4'hF) quiet_cnt <= quiet_cnt + 4'h1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) last_cfg <= 8'h00;
        else if (psel && !penable && clk_en && pwrite && paddr == 12'h0B8 && pstrb[0])
            last_cfg <= pwdata[7:0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable && clk_en; endsequence
    sequence s_rd(logic [11:0] a); psel && !penable && clk_en && !pwrite && paddr == a; endsequence
    sequence s_cfg_wr; s_setup ##0 (pwrite && paddr == 12'h0B8 && pstrb[0]); endsequence
    a_ready_next: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_ready_pulse: assert property (pready && clk_en |=> !pready)
        else $error("pready longer than one cycle");
    a_gain_live: assert property (s_rd(12'h0B4) ##0 quiet_cnt >= 4'h8
        |=> prdata == {24'h000000, frontend.am_gain_cut, frontend.pm_gain_cut})
        else $error("gain state differs from live gain cut");
    a_cal_live: assert property (s_rd(12'h0BC) ##0 quiet_cnt >= 4'h8
        |=> prdata == {24'h000000, cal_report.cal_value, cal_report.cal_done,
                       cal_report.cal_error, 1'b0})
        else $error("sensor result differs from calibration report");
    a_aux_live: assert property (s_rd(12'h0C0) ##0 quiet_cnt >= 4'h8
        |=> prdata[7:0] == frontend[7:0])
        else $error("auxiliary status differs from live state");
    a_high_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_unmapped_err: assert property (s_rd(12'h000) |=> pready && pslverr)
        else $error("no error on unmapped read");
    a_mapped_ok: assert property (s_setup ##0 (paddr inside {12'h0B4, 12'h0B8, 12'h0BC,
        12'h0C0, 12'h100, 12'h104, 12'h108}) |=> !pslverr)
        else $error("error on mapped register");
    a_auto_sel: assert property (sensor_cfg.auto_cal == (sensor_cfg.manual_cal == 5'h00))
        else $error("auto calibration select wrong");
    a_gain_codes: assert property (sensor_cfg.gain_valid
        == (sensor_cfg.gain inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h6}))
        else $error("gain code validity wrong");
    a_cfg_apply: assert property (s_cfg_wr |-> ##[1:2] {sensor_cfg.manual_cal, sensor_cfg.gain} == last_cfg)
        else $error("sensor settings not applied");
    a_ctrl_back: assert property (s_rd(12'h0B8) |=> prdata[7:0] == {sensor_cfg.manual_cal, sensor_cfg.gain})
        else $error("control readback differs from settings");
    a_reset_clear: assert property ($rose(presetn)
        |-> prdata == 32'h0 && sensor_cfg == 10'h201 && !irq)
        else $error("outputs not clear after reset");
endmodule : rssr_regs_checker

bind rssr_regs rssr_regs_checker u_rssr_regs_checker (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frontend(frontend), .cal_report(cal_report),
    .sensor_cfg(sensor_cfg), .irq(irq)
);

// [sim/testbench.sv]
// Purpose: Self-checking bench of the receiver and sensor status bank
// Assumes: APB master in the bench, live inputs driven from an LFSR
// Notes:   Read results are noted in a queue and checked by a monitor
`timescale 1ns/1ns
`include "rssr_params.svh"
module testbench;
    import rssr_pkg::*;
    typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} rssr_note_t;
    localparam logic [11:0] addr_gain = 12'h0B4;
    localparam logic [11:0] addr_ctrl = 12'h0B8;
    localparam logic [11:0] addr_res  = 12'h0BC;
    localparam logic [11:0] addr_aux  = 12'h0C0;
    localparam logic [11:0] addr_irq  = 12'h100;
    localparam logic [11:0] addr_mask = 12'h104;
    localparam logic [11:0] addr_cmd  = 12'h108;
    localparam logic [7:0]  cfg_tab [8] = '{8'h00, 8'hF9, 8'h0A, 8'h7C, 8'h86, 8'hAB, 8'h55, 8'h01};
    logic             pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, seed;
    logic [3:0]       pstrb;
    rssr_frontend_t   frontend;
    rssr_cal_t        cal_report;
    rssr_sensor_cfg_t sensor_cfg;
    rssr_note_t       exp_q [$];
    int               fail_count = 0, n_tests = 0, cycles = 0;

    rssr_regs u_rssr_regs (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frontend(frontend), .cal_report(cal_report),
        .sensor_cfg(sensor_cfg), .irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic compare_val(input string what, input logic [31:0] expv,
                               input logic [31:0] seen);
        n_tests++;
        if (seen !== expv) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, expv, seen);
        end
    endtask : compare_val

    task automatic compare_bus(input rssr_note_t n, input logic [31:0] d, input logic e);
        n_tests++;
        if (((d & n.mask) !== n.data) || (e !== n.err)) begin
            fail_count++;
            $display("wrong value prdata expected %h err %b seen %h err %b", n.data, n.err, d, e);
        end
    endtask : compare_bus

    // ------------------------------------------------------------
    // APB master, result noted before the transfer starts
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       input logic [31:0] ed, input logic [31:0] em, input logic ee);
        rssr_note_t n;
        int         guard;
        n = '{ed, em, ee};
        guard = 0;
        exp_q.push_back(n);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            guard++;
        end while (pready !== 1'b1 && guard < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (guard >= 50) begin
            fail_count++;
            print_verdict();
        end
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] ed);
        apb(1'b0, a, 32'h0, ed, 32'hFFFFFFFF, 1'b0);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, 32'h0, 32'h0, 1'b0);
    endtask : wr

    // Monitor takes the oldest note at each answer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                compare_val("unexpected answer", 32'h0, 32'h1);
            end else begin
                compare_bus(exp_q.pop_front(), prdata, pslverr);
            end
        end
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    initial begin
        int             i;
        logic [7:0]     b;
        rssr_frontend_t fe;
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        frontend = '0;
        cal_report = '0;
        seed = 32'hB2DA;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(addr_gain, 32'h0);
        rd(addr_ctrl, 32'h0);
        rd(addr_res, 32'h0);
        rd(addr_aux, 32'h0);
        apb(1'b0, 12'h000, 32'h0, 32'h0, 32'h0, `RSSR_PSLVERR_UNMAPPED);
        // ------------------------------------------------------------
        // Interrupt: masked event, unmasked event, read clear
        // ------------------------------------------------------------
        frontend.osc_stable <= 1'b1;
        repeat (8) @(posedge pclk);
        compare_val("irq masked", 32'h0, {31'h0, irq});
        wr(addr_mask, 32'h1 << `RSSR_IRQ_FIELD_ON);
        frontend.field_detected <= 1'b1;
        repeat (8) @(posedge pclk);
        compare_val("irq raised", 32'h1, {31'h0, irq});
        rd(addr_irq, (32'h1 << `RSSR_IRQ_FIELD_ON) | (32'h1 << `RSSR_IRQ_OSC_OK));
        repeat (3) @(posedge pclk);
        compare_val("irq cleared", 32'h0, {31'h0, irq});
        rd(addr_mask, 32'h1 << `RSSR_IRQ_FIELD_ON);
        cal_report <= 7'h03;
        frontend.rx_busy <= 1'b1;
        repeat (8) @(posedge pclk);
        rd(addr_irq, (32'h1 << `RSSR_IRQ_CAL_END) | (32'h1 << `RSSR_IRQ_CAL_ERR)
            | (32'h1 << `RSSR_IRQ_RX_START));
        // ------------------------------------------------------------
        // Live status with writes to read-only places in between
        // ------------------------------------------------------------
        for (i = 0; i < 6; i++) begin
            seed = lfsr_next(seed);
            fe = seed[15:0];
            frontend <= fe;
            cal_report <= seed[22:16];
            repeat (8) @(posedge pclk);
            wr(i % 3 == 0 ? addr_gain : (i % 3 == 1 ? addr_res : addr_aux), ~seed);
            rd(addr_gain, {24'h0, fe.am_gain_cut, fe.pm_gain_cut});
            rd(addr_res, {24'h0, seed[22:16], 1'b0});
            rd(addr_aux, {24'h0, fe.pm_selected, fe.field_detected, fe.tx_active,
                fe.osc_stable, fe.rx_enabled, fe.rx_busy, fe.peer_detect_active,
                fe.collision_avoid_active});
        end
        // ------------------------------------------------------------
        // Sensor control codes, upper lanes carry noise
        // ------------------------------------------------------------
        for (i = 0; i < 8; i++) begin
            b = cfg_tab[i];
            seed = lfsr_next(seed);
            wr(addr_ctrl, {seed[31:8], b});
            rd(addr_ctrl, {24'h0, b});
            compare_val("sensor_cfg", {22'h0, b[7:3] == 5'h00, b, b[2:0] inside {3'h0, 3'h1, 3'h2,
                3'h4, 3'h6}}, {22'h0, sensor_cfg});
        end
        wr(addr_ctrl, 32'h000000F9);
        wr(addr_cmd, {24'h000000, `RSSR_CMD_SET_DEFAULT});
        rd(addr_ctrl, 32'h0);
        compare_val("sensor_cfg default", {22'h0, 1'b1, 8'h00, 1'b1}, {22'h0, sensor_cfg});
        print_verdict();
    end
endmodule : testbench
